/* verification/async_serial_tx_rx_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_sva
    import serial_port_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_baud_tick,
    input wire logic i_ovs_tick,
    input wire logic [1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic i_rx_pin,
    input wire logic o_tx_pin,
    input wire logic o_tx_oe,
    input wire logic o_tx_irq
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // Completed control write and status read
    logic ctl_done;
    logic st_done;
    assign ctl_done = i_write && !o_waitrequest && (i_address == ADDR_CTRL);
    assign st_done = i_read && !o_waitrequest && (i_address == ADDR_STATUS);
    // ********
    // Bus and pin properties
    // ********
    property p_wait_low;
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
    endproperty
    a_wait_low: assert property (p_wait_low)
        else $error("access not answered after one wait cycle");
    property p_wait_pulse;
        !o_waitrequest |=> o_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");
    // Read data must not drift between accesses
    property p_rdata_hold;
        !i_read && o_waitrequest && $past(o_waitrequest) |-> $stable(o_readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    property p_oe_on;
        ctl_done && i_writedata[CTL_PORT_EN] |-> ##2 o_tx_oe;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("tx pin not driven after port enable");
    property p_oe_off;
        ctl_done && !i_writedata[CTL_PORT_EN] |-> ##2 !o_tx_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("tx pin still driven after port disable");
    property p_irq_off;
        ctl_done && !i_writedata[CTL_TX_IE] |-> ##2 !o_tx_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("tx irq raised with its enable clear");
    property p_irq_txoff;
        ctl_done && !i_writedata[CTL_TX_EN] |-> ##2 !o_tx_irq;
    endproperty
    a_irq_txoff: assert property (p_irq_txoff)
        else $error("tx irq raised with transmitter off");
    property p_irq_flag;
        st_done && o_readdata[ST_TX_IRQ] |-> o_readdata[ST_TX_EMPTY];
    endproperty
    a_irq_flag: assert property (p_irq_flag)
        else $error("tx irq shown without empty flag");
    // Pin moves only on a bit tick or shortly after a register write
    property p_pin_tick;
        $changed(o_tx_pin) |-> $past(i_baud_tick) || $past(i_baud_tick, 2)
            || $past(i_baud_tick, 3) || $past(i_write) || $past(i_write, 2);
    endproperty
    a_pin_tick: assert property (p_pin_tick)
        else $error("tx pin changed away from a baud tick");
endmodule : async_serial_tx_rx_sva
`default_nettype wire

/* verification/async_serial_tx_rx_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_tb
    import serial_port_pkg::*;
    ;
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic i_baud_tick = 1'b0, i_ovs_tick = 1'b0, send = 1'b0, o_waitrequest, o_tx_pin;
    logic [1:0] i_address = 2'h0;
    logic [31:0] i_writedata = 32'h0, o_readdata, rd;
    logic o_tx_oe, o_tx_irq, busy, line, b, act = 1'b0, inv = 1'b0, mon = 1'b1;
    logic [11:0] bits = 12'h000;
    logic [3:0] nbits = 4'h1;
    logic [4:0] bticks = 5'h10;
    logic [5:0] div = 6'h00;
    logic [10:0] rec = 11'h000;
    logic [10:0] txq[$];
    int mismatches = 0, checked = 0, cycles = 0, cnt = 0, tx_len = 10;
    async_serial_tx_rx async_serial_tx_rx_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_baud_tick(i_baud_tick), .i_ovs_tick(i_ovs_tick), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rx_pin(line),
        .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_tx_irq(o_tx_irq));
    serial_node_model serial_node_model_i (.i_ref_clk(i_ref_clk), .i_ovs_tick(i_ovs_tick),
        .i_send(send), .i_bits(bits), .i_nbits(nbits), .i_bit_ticks(bticks),
        .o_line(line), .o_busy(busy));
    // ********
    // Clock, tick source, line monitor
    // ********
    initial begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    // Short tick periods keep ten-bit frames at 640 cycles, eleven-bit frames at 704
    always @(posedge i_ref_clk) begin
        div <= div + 6'h01;
        i_ovs_tick <= (div[1:0] == 2'h3);
        i_baud_tick <= (div == 6'h3F);
    end
    // Tx frames sampled at each baud tick, start bit first
    always @(posedge i_ref_clk) begin
        cycles++;
        b = o_tx_pin ^ inv;
        if (mon && !act && !b) begin
            act = 1'b1;
            cnt = 0;
            rec = 11'h000;
        end
        if (act && i_baud_tick) begin
            rec[cnt] = b;
            cnt++;
            if (cnt == tx_len) begin
                txq.push_back(rec);
                act = 1'b0;
            end
        end
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_ref_clk);
        end while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus
    task automatic status(input logic [31:0] mask, input logic [31:0] exp, input string name);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(name, rd & mask, exp);
    endtask : status
    task automatic pins(input logic [2:0] exp, input string name);
        repeat (2) @(negedge i_ref_clk);
        check(name, {29'h0, o_tx_irq, o_tx_oe, o_tx_pin}, {29'h0, exp});
    endtask : pins
    task automatic go();
        @(posedge i_ref_clk);
        send <= 1'b1;
        @(posedge i_ref_clk);
        send <= 1'b0;
        @(negedge i_ref_clk);
        while (busy) @(negedge i_ref_clk);
    endtask : go
    task automatic put(input logic [8:0] d, input logic nine, input logic stop);
        bits = nine ? {1'b1, stop, d, 1'b0} : {2'b11, stop, d[7:0], 1'b0};
        nbits = nine ? 4'hB : 4'hA;
        bticks = 5'h10;
        go();
    endtask : put
    task automatic tx_check(input logic [10:0] exp);
        while (txq.size() == 0) @(posedge i_ref_clk);
        check("tx frame", {21'h0, txq.pop_front()}, {21'h0, exp});
    endtask : tx_check
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ********
    // Test sequence
    // ********
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, {23'h0, CTL_RESET});
        status(32'h7F, 32'h02, "status reset");
        pins(3'h1, "pins reset");
        $display("test reset done");
        bus(1'b1, ADDR_CTRL, 32'h103);
        status(32'h7F, 32'h43, "status tx on");
        pins(3'h7, "pins irq on");
        bus(1'b1, ADDR_CTRL, 32'h003);
        status(32'h7F, 32'h03, "status irq off");
        $display("test enable done");
        bus(1'b1, ADDR_TX_DATA, 32'hA5);
        bus(1'b1, ADDR_TX_DATA, 32'h3C);
        // Flag is not valid straight after the write
        repeat (4) @(posedge i_ref_clk);
        status(32'h03, 32'h00, "status queued");
        tx_check(11'h34A);
        tx_check(11'h278);
        status(32'h03, 32'h03, "status drained");
        $display("test back to back done");
        mon = 1'b0;
        bus(1'b1, ADDR_CTRL, 32'hB3);
        pins(3'h2, "pins inverted idle");
        inv = 1'b1;
        tx_len = 11;
        mon = 1'b1;
        bus(1'b1, ADDR_TX_DATA, 32'h5A);
        tx_check(11'h6B4);
        mon = 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h07);
        status(32'h01, 32'h00, "status sync off");
        bus(1'b1, ADDR_CTRL, 32'h0B);
        pins(3'h3, "pins true idle");
        inv = 1'b0;
        mon = 1'b1;
        $display("test nine bit done");
        put(9'h096, 1'b0, 1'b1);
        put(9'h03C, 1'b0, 1'b0);
        put(9'h011, 1'b0, 1'b1);
        put(9'h022, 1'b0, 1'b1);
        repeat (24) @(posedge i_ref_clk);
        status(32'h1F, 32'h0F, "status overrun");
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        check("rx first", rd & 32'hFF, 32'h96);
        status(32'h1F, 32'h1F, "status framing");
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        check("rx second", rd & 32'hFF, 32'h3C);
        status(32'h0F, 32'h0B, "status emptied");
        bus(1'b1, ADDR_CTRL, 32'h03);
        bus(1'b1, ADDR_CTRL, 32'h4B);
        status(32'h0F, 32'h03, "status cleared");
        $display("test overrun done");
        // Short low pulse, a quarter bit, then quiet line
        bits = 12'h000;
        bticks = 5'h04;
        nbits = 4'h1;
        go();
        repeat (128) @(posedge i_ref_clk);
        put(9'h1C9, 1'b1, 1'b1);
        repeat (24) @(posedge i_ref_clk);
        status(32'h3F, 32'h27, "status nine");
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        check("rx nine", rd & 32'hFF, 32'hC9);
        status(32'h04, 32'h00, "status abandoned");
        $display("test receive done");
        end_sim();
    end
endmodule : async_serial_tx_rx_tb
bind async_serial_tx_rx async_serial_tx_rx_sva async_serial_tx_rx_sva_i (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_baud_tick(i_baud_tick),
    .i_ovs_tick(i_ovs_tick), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_tx_irq(o_tx_irq)
);
`default_nettype wire

/* verification/serial_node_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_node_model (
    input wire logic i_ref_clk,
    input wire logic i_ovs_tick,
    input wire logic i_send,
    input wire logic [11:0] i_bits,
    input wire logic [3:0] i_nbits,
    input wire logic [4:0] i_bit_ticks,
    output logic o_line,
    output logic o_busy
);
    logic [11:0] sh;
    logic [3:0] left;
    logic [4:0] tk;
    // ********
    // Remote node: each bit held for i_bit_ticks oversample ticks
    // ********
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
    end
    // Line rests at mark between frames, like a pulled-up wire
    always @(posedge i_ref_clk) begin
        if (i_send && !o_busy) begin
            sh <= i_bits;
            left <= i_nbits;
            tk <= 5'h00;
            o_busy <= 1'b1;
            o_line <= i_bits[0];
        end else if (o_busy && i_ovs_tick) begin
            if (tk != i_bit_ticks - 5'h01) begin
                tk <= tk + 5'h01;
            end else if (left == 4'h1) begin
                o_busy <= 1'b0;
                o_line <= 1'b1;
            end else begin
                tk <= 5'h00;
                left <= left - 4'h1;
                sh <= sh >> 1;
                o_line <= sh[1];
            end
        end
    end
endmodule : serial_node_model
`default_nettype wire

/* verilog/async_serial_tx_rx.sv */
// Function
// - Transmitter runs only with tx enable, async select and port enable; port drives tx pin.
// - Setting tx enable sets the transmit-buffer-empty flag immediately.
// - Holding-buffer write starts transmission; idle shifter takes character at once.
// - Busy shifter: hold character until stop sent, then load and start next frame.
// - Polarity invert 0 gives high idle true data; 1 inverts idle and data.
// - Buffer-empty flag set when enabled and holding empty; clear when queued or when transmitter is off.
// - Buffer-empty flag shows new value three cycles after a holding write.
// - Flag independent of irq enable; transmit irq request needs enable too.
// - Shift-empty status set when shifter empty, clear from load until shifted out.
// - Nine-bit select shifts nine data bits, ninth bit being most significant.
// - Receiver oversamples sixteen times per bit; shift register advances once per bit.
// - Received characters enter two-entry FIFO; third may be in progress.
// - Receiver active only with continuous enable, async select and port enable.
// - Start edge rechecked at half bit; high line abandons silently.
// - Each following bit sampled a bit time later by majority vote.
// - Stop bit sampled after last data bit; zero sets framing error.
// - After stop, character enters FIFO, available flag set; read pops oldest.
// - While overrun exists no further characters are accepted.
// - Frame is low start, 8 or 9 data bits LSB first, high stop.
// - Overrun set on third character with FIFO full; cleared by disabling.
// - Each entry keeps framing bit; status shows oldest; port disable clears.
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx
    import serial_port_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_baud_tick,
    input wire logic i_ovs_tick,
    input wire logic [1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_rx_pin,
    output logic o_tx_pin,
    output logic o_tx_oe,
    output logic o_tx_irq
);

    // ****************************************
    // State
    // ****************************************
    serial_state_t s_reg;
    serial_state_t s_next;

    logic tx_run;
    logic rx_run;
    logic tx_empty_flag;
    logic rx_bit;
    logic bus_rd;
    logic bus_wr;

    // Majority of three samples
    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : majority

    // Data bit count from the nine-bit select
    function automatic logic [3:0] frame_bits(input logic nine);
        frame_bits = nine ? BITS_NINE : BITS_EIGHT;
    endfunction : frame_bits

    // ****************************************
    // Combinational next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        tx_run = s_reg.ctrl[CTL_TX_EN] & ~s_reg.ctrl[CTL_SYNC] & s_reg.ctrl[CTL_PORT_EN];
        rx_run = s_reg.ctrl[CTL_RX_EN] & ~s_reg.ctrl[CTL_SYNC] & s_reg.ctrl[CTL_PORT_EN];
        tx_empty_flag = s_reg.txf_shown;
        bus_rd = i_read & s_reg.wait_req;
        bus_wr = i_write & s_reg.wait_req;
        rx_bit = s_reg.rx_level;

        // Bus: one wait cycle, then the access completes
        s_next.wait_req = 1'b1;
        if ((i_read | i_write) & s_reg.wait_req) begin
            s_next.wait_req = 1'b0;
        end
        bus_rd = i_read & ~s_reg.wait_req;
        bus_wr = i_write & ~s_reg.wait_req;

        if (bus_wr && i_address == ADDR_CTRL) begin
            s_next.ctrl = i_writedata[CTL_WIDTH-1:0];
        end

        // Port enable drives the tx pin as output
        s_next.tx_oe = s_next.ctrl[CTL_PORT_EN];

        // Read data latched as the read is taken; it stands until the next read
        if (i_read && s_reg.wait_req) begin
            s_next.rdata = 32'h0000_0000;
            unique case (i_address)
                ADDR_CTRL: s_next.rdata[CTL_WIDTH-1:0] = s_reg.ctrl;
                ADDR_STATUS: begin
                    s_next.rdata[ST_TX_EMPTY] = tx_empty_flag;
                    s_next.rdata[ST_SHIFT_EMPTY] = (s_reg.tx_st == TX_IDLE);
                    s_next.rdata[ST_RX_AVAIL] = (s_reg.fifo_cnt != 2'h0);
                    s_next.rdata[ST_OVERRUN] = s_reg.overrun;
                    s_next.rdata[ST_FRAMING] = (s_reg.fifo_cnt != 2'h0) & s_reg.fifo[0].frame_err;
                    s_next.rdata[ST_RX9D] = s_reg.fifo[0].data[8];
                    s_next.rdata[ST_TX_IRQ] = o_tx_irq;
                end
                ADDR_TX_DATA: s_next.rdata[8:0] = s_reg.hold;
                ADDR_RX_DATA: s_next.rdata[8:0] = s_reg.fifo[0].data;
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end

        // ****************************************
        // Transmitter
        // ****************************************
        // Holding write keeps ninth bit from control, written earlier by software
        if (bus_wr && i_address == ADDR_TX_DATA && tx_run) begin
            s_next.hold = {s_reg.ctrl[CTL_TX_NINTH_BIT], i_writedata[7:0]};
            s_next.hold_full = 1'b1;
            s_next.txf_wait = TXF_DELAY;
        end

        unique case (s_reg.tx_st)
            TX_IDLE: begin
                // Idle shifter takes the character straight away
                if (s_reg.hold_full && tx_run) begin
                    s_next.tx_shift = s_reg.hold;
                    s_next.hold_full = s_next.hold_full & bus_wr & (i_address == ADDR_TX_DATA);
                    s_next.tx_st = TX_START;
                end
            end
            TX_START: begin
                if (i_baud_tick) begin
                    s_next.tx_st = TX_DATA;
                    s_next.tx_cnt = 4'h0;
                end
            end
            TX_DATA: begin
                if (i_baud_tick) begin
                    s_next.tx_shift = {1'b0, s_reg.tx_shift[8:1]};
                    s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
                    if (s_reg.tx_cnt + 4'h1 == frame_bits(s_reg.ctrl[CTL_TX9])) begin
                        s_next.tx_st = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                // Pending character loads in the cycle after the stop bit ends
                if (i_baud_tick) begin
                    s_next.tx_st = TX_IDLE;
                end
            end
            default: s_next.tx_st = TX_IDLE;
        endcase
        if (!tx_run) begin
            s_next.tx_st = TX_IDLE;
            s_next.hold_full = 1'b0;
        end

        // Line level before polarity
        s_next.tx_line = 1'b1;
        unique case (s_next.tx_st)
            TX_START: s_next.tx_line = 1'b0;
            TX_DATA: s_next.tx_line = s_next.tx_shift[0];
            default: s_next.tx_line = 1'b1;
        endcase
        s_next.tx_line = s_next.tx_line ^ s_next.ctrl[CTL_INVERT];

        // Empty flag: enabled and nothing queued, shown after the write settles
        if (s_reg.txf_wait != 2'h0) begin
            s_next.txf_wait = s_reg.txf_wait - 2'h1;
        end else begin
            s_next.txf_shown = tx_run & ~s_reg.hold_full;
        end
        if (!tx_run) begin
            s_next.txf_shown = 1'b0;
            s_next.txf_wait = 2'h0;
        end
        if (tx_run && !s_reg.txf_shown && s_reg.tx_st == TX_IDLE && !s_reg.hold_full) begin
            s_next.txf_shown = 1'b1;
        end

        // ****************************************
        // Receiver
        // ****************************************
        s_next.rx_sync = {s_reg.rx_sync[1:0], i_rx_pin};
        if (s_reg.rx_sync[2] == s_reg.rx_sync[1]) begin
            s_next.rx_level = s_reg.rx_sync[1];
        end

        if (i_ovs_tick) begin
            s_next.ovs = s_reg.ovs + 4'h1;
            if (s_reg.ovs == OVS_MID_A || s_reg.ovs == OVS_MID_B || s_reg.ovs == OVS_MID_C) begin
                s_next.votes = {s_reg.votes[1:0], rx_bit};
            end
        end

        unique case (s_reg.rx_st)
            RX_IDLE: begin
                s_next.ovs = 4'h0;
                if (!rx_bit && rx_run && !s_reg.overrun) begin
                    s_next.rx_st = RX_START;
                end
            end
            RX_START: begin
                // Counter keeps running, so every later window opens on a bit edge
                if (i_ovs_tick && s_reg.ovs == OVS_HALF && rx_bit) begin
                    s_next.rx_st = RX_IDLE;
                end else if (i_ovs_tick && s_reg.ovs == OVS_LAST) begin
                    s_next.rx_cnt = 4'h0;
                    s_next.rx_st = RX_DATA;
                end
            end
            RX_DATA: begin
                // Votes sit mid-window; the bit is taken as its window closes
                if (i_ovs_tick && s_reg.ovs == OVS_LAST) begin
                    s_next.rx_shift = {majority(s_reg.votes), s_reg.rx_shift[8:1]};
                    s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
                    if (s_reg.rx_cnt + 4'h1 == frame_bits(s_reg.ctrl[CTL_RX9])) begin
                        s_next.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (i_ovs_tick && s_reg.ovs == OVS_LAST) begin
                    s_next.rx_st = RX_IDLE;
                    if (s_reg.fifo_cnt == FIFO_DEPTH) begin
                        s_next.overrun = 1'b1;
                    end else begin
                        // Eight-bit frames sit right-aligned, ninth bit zero
                        s_next.fifo[s_reg.fifo_cnt[0]].data = s_reg.ctrl[CTL_RX9] ?
                            s_reg.rx_shift : {1'b0, s_reg.rx_shift[8:1]};
                        s_next.fifo[s_reg.fifo_cnt[0]].frame_err = ~majority(s_reg.votes);
                        s_next.fifo_cnt = s_reg.fifo_cnt + 2'h1;
                    end
                end
            end
            default: s_next.rx_st = RX_IDLE;
        endcase

        // Pop oldest on a data read; a push in the same cycle lands behind it
        if (bus_rd && i_address == ADDR_RX_DATA && s_reg.fifo_cnt != 2'h0) begin
            s_next.fifo[0] = s_next.fifo[1];
            s_next.fifo_cnt = s_next.fifo_cnt - 2'h1;
        end

        if (!rx_run) begin
            s_next.rx_st = RX_IDLE;
            s_next.overrun = 1'b0;
        end
        // Port disable resets stored characters and their framing bits
        if (!s_reg.ctrl[CTL_PORT_EN]) begin
            s_next.fifo_cnt = 2'h0;
            s_next.fifo[0].frame_err = 1'b0;
            s_next.fifo[1].frame_err = 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            s_reg <= '0;
            s_reg.ctrl <= CTL_RESET;
            s_reg.tx_st <= TX_IDLE;
            s_reg.rx_st <= RX_IDLE;
            s_reg.tx_line <= 1'b1;
            s_reg.rx_sync <= 3'h7;
            s_reg.rx_level <= 1'b1;
            s_reg.wait_req <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Irq request gated by its enable
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_tx_irq <= 1'b0;
        end else begin
            o_tx_irq <= s_next.txf_shown & s_next.ctrl[CTL_TX_IE];
        end
    end

    // Outputs from flip-flops
    assign o_tx_pin = s_reg.tx_line;
    assign o_tx_oe = s_reg.tx_oe;
    assign o_readdata = s_reg.rdata;
    assign o_waitrequest = s_reg.wait_req;

endmodule : async_serial_tx_rx
`default_nettype wire

/* verilog/serial_port_pkg.sv */
`default_nettype none
package serial_port_pkg;

    // ****************************************
    // Register map (Avalon-MM word addresses)
    // ****************************************
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_TX_DATA = 2'h2;
    localparam logic [1:0] ADDR_RX_DATA = 2'h3;

    // Control register bit positions
    localparam int CTL_PORT_EN = 0;
    localparam int CTL_TX_EN = 1;
    localparam int CTL_SYNC = 2;
    localparam int CTL_RX_EN = 3;
    localparam int CTL_INVERT = 4;
    localparam int CTL_TX9 = 5;
    localparam int CTL_RX9 = 6;
    localparam int CTL_TX_NINTH_BIT = 7;
    localparam int CTL_TX_IE = 8;
    localparam int CTL_WIDTH = 9;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h000;

    // Status register bit positions
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_SHIFT_EMPTY = 1;
    localparam int ST_RX_AVAIL = 2;
    localparam int ST_OVERRUN = 3;
    localparam int ST_FRAMING = 4;
    localparam int ST_RX9D = 5;
    localparam int ST_TX_IRQ = 6;

    // ****************************************
    // Frame and timing constants
    // ****************************************
    localparam logic [3:0] OVS_HALF = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID_A = 4'h6;
    localparam logic [3:0] OVS_MID_B = 4'h7;
    localparam logic [3:0] OVS_MID_C = 4'h8;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [1:0] TXF_DELAY = 2'h2;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

    // One received character with its own framing error
    typedef struct packed {
        logic frame_err;
        logic [8:0] data;
    } rx_entry_t;

    typedef struct packed {
        logic [CTL_WIDTH-1:0] ctrl;
        logic [8:0] hold;
        logic hold_full;
        logic [1:0] txf_wait;
        logic txf_shown;
        tx_state_t tx_st;
        logic [8:0] tx_shift;
        logic [3:0] tx_cnt;
        logic tx_line;
        logic tx_oe;
        logic [2:0] rx_sync;
        logic rx_level;
        rx_state_t rx_st;
        logic [3:0] ovs;
        logic [3:0] rx_cnt;
        logic [2:0] votes;
        logic [8:0] rx_shift;
        rx_entry_t [1:0] fifo;
        logic [1:0] fifo_cnt;
        logic overrun;
        logic [31:0] rdata;
        logic rvalid_wait;
        logic wait_req;
    } serial_state_t;

endpackage : serial_port_pkg
`default_nettype wire
